// ===== verilog/insn_decoder.sv
// Opcode decoder and execution sequencer for a subset of the core
module insn_decoder import decode_pkg::*; #(
  parameter int STEP_W = 4 // Step counter width
) (
  input wire logic SYS_CLK, // System clock
  input wire logic RST, // Synchronous reset
  input wire logic FETCH_VALID, // Opcode byte offered
  input wire logic [7:0] FETCH_BYTE, // Opcode byte
  output logic FETCH_READY, // Opcode byte taken when valid
  input wire logic [15:0] OPERAND, // Operand value, held while busy
  input wire logic [15:0] STACK_DATA, // Stack word, cycle after read
  output logic STACK_RD, // Stack read strobe
  output logic [15:0] STACK_ADDR, // Stack read address
  output logic MEM_WR, // Memory write strobe
  output logic MEM_WIDE, // Write is a word
  output logic [15:0] MEM_WDATA, // Write data
  output logic BUSY, // Executing
  output logic RETIRE, // Last cycle of instruction
  output logic ILLEGAL, // Unknown opcode seen
  output logic [15:0] REG_D, // Accumulators A:B
  output logic [15:0] REG_E, // Accumulator E
  output logic [15:0] REG_CCR, // condition_code_word
  output logic [15:0] REG_PC, // Program counter
  output logic [15:0] REG_SP // Stack pointer
);
  if (STEP_W != 4) begin : g_chk
    $error("STEP_W must be 4");
  end

  core_t r_r; // Registered state
  core_t r_nxt; // Next state
  dec_t dec; // Decode of offered byte
  logic take_w; // Final opcode byte taken
  logic is_pfx; // Offered byte is a prefix
  logic [1:0] pg_w; // Page of offered byte
  logic [15:0] alu_a; // ALU operands and results
  logic [15:0] alu_b;
  logic alu_cin;
  logic alu_sub;
  logic alu_wide;
  logic [15:0] alu_res;
  logic alu_n;
  logic alu_z;
  logic alu_v;
  logic alu_c;
  logic [15:0] rot; // Rotated word

  // Page decoded opcode table
  function automatic dec_t decode(input logic [1:0] pg, input logic [7:0] by);
    dec_t d;
    d = '{ok: 1'b1, op: OP_NONE, cyc: CYC_MEM};
    case ({pg, by})
      {PG_NONE, 8'h42}, {PG_NONE, 8'h52}, {PG_NONE, 8'h62},
      {PG_17, 8'h42}, {PG_17, 8'h52}, {PG_17, 8'h62}, {PG_17, 8'h72},
      {PG_27, 8'h42}, {PG_27, 8'h52}, {PG_27, 8'h62}: d.op = OP_SUB_WITH_BORROW_ACC_A;
      {PG_NONE, 8'h72}: begin
        d.op = OP_SUB_WITH_BORROW_ACC_A;
        d.cyc = CYC_SHORT;
      end
      {PG_NONE, 8'hC2}, {PG_NONE, 8'hD2}, {PG_NONE, 8'hE2},
      {PG_17, 8'hC2}, {PG_17, 8'hD2}, {PG_17, 8'hE2}, {PG_17, 8'hF2},
      {PG_27, 8'hC2}, {PG_27, 8'hD2}, {PG_27, 8'hE2}: d.op = OP_SUB_WITH_BORROW_ACC_B;
      {PG_NONE, 8'hF2}: begin
        d.op = OP_SUB_WITH_BORROW_ACC_B;
        d.cyc = CYC_SHORT;
      end
      {PG_NONE, 8'h82}, {PG_NONE, 8'h92}, {PG_NONE, 8'hA2},
      {PG_37, 8'hC2}, {PG_37, 8'hD2}, {PG_37, 8'hE2}, {PG_37, 8'hF2},
      {PG_27, 8'h82}, {PG_27, 8'h92}, {PG_27, 8'hA2}: d.op = OP_SUB_WITH_BORROW_ACC_D;
      {PG_37, 8'hB2}: begin
        d.op = OP_SUB_WITH_BORROW_ACC_D;
        d.cyc = CYC_IMM16;
      end
      {PG_37, 8'h42}, {PG_37, 8'h52}, {PG_37, 8'h62}, {PG_37, 8'h72}: d.op = OP_SUB_WITH_BORROW_ACC_E;
      {PG_37, 8'h32}: begin
        d.op = OP_SUB_WITH_BORROW_ACC_E;
        d.cyc = CYC_IMM16;
      end
      {PG_37, 8'h43}, {PG_37, 8'h53}, {PG_37, 8'h63}, {PG_37, 8'h73}: d.op = OP_ADD_WITH_CARRY_ACC_E;
      {PG_37, 8'h33}: begin
        d.op = OP_ADD_WITH_CARRY_ACC_E;
        d.cyc = CYC_IMM16;
      end
      {PG_27, 8'h77}: begin
        d.op = OP_RTE;
        d.cyc = CYC_STACK;
      end
      {PG_27, 8'hF7}: begin
        d.op = OP_RTS;
        d.cyc = CYC_STACK;
      end
      {PG_27, 8'h0E}, {PG_27, 8'h1E}, {PG_27, 8'h2E}, {PG_27, 8'h3E}: begin
        d.op = OP_ROTW;
        d.cyc = CYC_ROT;
      end
      {PG_27, 8'h79}: begin
        d.op = OP_SDE;
        d.cyc = CYC_SHORT;
      end
      {PG_37, 8'h0A}: begin
        d.op = OP_SBAB;
        d.cyc = CYC_SHORT;
      end
      {PG_17, 8'h4A}, {PG_17, 8'h5A}, {PG_17, 8'h6A}, {PG_17, 8'h7A}: d.op = OP_STORE_ACC_A;
      {PG_NONE, 8'h4A}, {PG_NONE, 8'h5A}, {PG_NONE, 8'h6A},
      {PG_27, 8'h4A}, {PG_27, 8'h5A}, {PG_27, 8'h6A}: begin
        d.op = OP_STORE_ACC_A;
        d.cyc = CYC_STORE_SHORT;
      end
      default: d.ok = 1'b0;
    endcase
    return d;
  endfunction

  // Prefix detection and decode of the offered byte
  always_comb begin
    is_pfx = (r_r.st == ST_IDLE) && (FETCH_BYTE == PFX_17 || FETCH_BYTE == PFX_27
      || FETCH_BYTE == PFX_37);
    pg_w = (r_r.st == ST_PAGE) ? r_r.page : PG_NONE;
    dec = decode(pg_w, FETCH_BYTE);
    take_w = FETCH_VALID && !is_pfx && (r_r.st == ST_IDLE || r_r.st == ST_PAGE);
  end

  // Operand steering into the adder
  always_comb begin
    alu_a = {8'h00, r_r.a};
    alu_b = OPERAND;
    alu_cin = r_r.condition_code_word[CC_C];
    alu_sub = 1'b1;
    alu_wide = 1'b0;
    case (r_r.op)
      OP_SUB_WITH_BORROW_ACC_B: alu_a = {8'h00, r_r.b};
      OP_SUB_WITH_BORROW_ACC_D: begin
        alu_a = {r_r.a, r_r.b};
        alu_wide = 1'b1;
      end
      OP_SUB_WITH_BORROW_ACC_E, OP_ADD_WITH_CARRY_ACC_E: begin
        alu_a = r_r.e;
        alu_wide = 1'b1;
        alu_sub = (r_r.op == OP_SUB_WITH_BORROW_ACC_E);
      end
      OP_SDE: begin
        alu_a = r_r.e;
        alu_b = {r_r.a, r_r.b};
        alu_cin = 1'b0;
        alu_wide = 1'b1;
      end
      OP_SBAB: begin
        alu_b = {8'h00, r_r.b};
        alu_cin = 1'b0;
      end
      default: alu_cin = r_r.condition_code_word[CC_C];
    endcase
  end

  addsub_unit u_alu (
    .a(alu_a),
    .b(alu_b),
    .cin(alu_cin),
    .sub(alu_sub),
    .wide(alu_wide),
    .res(alu_res),
    .n(alu_n),
    .z(alu_z),
    .v(alu_v),
    .c(alu_c)
  );

  assign rot = {r_r.condition_code_word[CC_C], OPERAND[15:1]}; // Carry enters at the top

  // Sequencer and execution
  always_comb begin
    r_nxt = r_r;
    r_nxt.wr = 1'b0;
    r_nxt.illegal = 1'b0;
    case (r_r.st)
      ST_IDLE, ST_PAGE: begin
        if (FETCH_VALID && is_pfx) begin
          r_nxt.st = ST_PAGE;
          r_nxt.page = FETCH_BYTE == PFX_17 ? PG_17 : (FETCH_BYTE == PFX_27 ? PG_27 : PG_37);
        end else if (take_w && dec.ok) begin
          r_nxt.st = ST_EXEC;
          r_nxt.op = dec.op;
          r_nxt.cyc = dec.cyc;
          r_nxt.step = STEP_FIRST;
        end else if (take_w) begin
          r_nxt.st = ST_IDLE; // Unknown opcode dropped
          r_nxt.page = PG_NONE;
          r_nxt.illegal = 1'b1;
        end
      end
      ST_EXEC: begin
        if (r_r.step == STEP_FIRST) begin
          case (r_r.op)
            OP_SUB_WITH_BORROW_ACC_A, OP_SBAB: r_nxt.a = alu_res[7:0];
            OP_SUB_WITH_BORROW_ACC_B: r_nxt.b = alu_res[7:0];
            OP_SUB_WITH_BORROW_ACC_D: {r_nxt.a, r_nxt.b} = alu_res;
            OP_SUB_WITH_BORROW_ACC_E, OP_SDE, OP_ADD_WITH_CARRY_ACC_E: r_nxt.e = alu_res;
            OP_STORE_ACC_A: begin
              r_nxt.wr = 1'b1;
              r_nxt.wide = 1'b0;
              r_nxt.wdata = {8'h00, r_r.a};
              r_nxt.condition_code_word[CC_N] = r_r.a[7];
              r_nxt.condition_code_word[CC_Z] = (r_r.a == 8'h00);
              r_nxt.condition_code_word[CC_V] = 1'b0;
            end
            OP_ROTW: begin
              r_nxt.wr = 1'b1;
              r_nxt.wide = 1'b1;
              r_nxt.wdata = rot;
              r_nxt.condition_code_word[CC_N] = r_r.condition_code_word[CC_C];
              r_nxt.condition_code_word[CC_Z] = (rot == 16'h0000);
              r_nxt.condition_code_word[CC_C] = OPERAND[0];
              r_nxt.condition_code_word[CC_V] = r_r.condition_code_word[CC_C] ^ OPERAND[0];
            end
            default: r_nxt.wr = 1'b0;
          endcase
          // Arithmetic flags only, upper flags left alone
          if (r_r.op inside {OP_SUB_WITH_BORROW_ACC_A, OP_SUB_WITH_BORROW_ACC_B, OP_SUB_WITH_BORROW_ACC_D, OP_SUB_WITH_BORROW_ACC_E, OP_SDE, OP_SBAB,
                             OP_ADD_WITH_CARRY_ACC_E}) begin
            r_nxt.condition_code_word[CC_N] = alu_n;
            r_nxt.condition_code_word[CC_Z] = alu_z;
            r_nxt.condition_code_word[CC_V] = alu_v;
            r_nxt.condition_code_word[CC_C] = alu_c;
          end
        end
        // Stack return sequence
        if (r_r.op == OP_RTE || r_r.op == OP_RTS) begin
          case (r_r.step)
            STK_INC1, STK_INC2: r_nxt.sp = r_r.sp + SP_STEP;
            STK_PULL1: begin
              if (r_r.op == OP_RTE) begin
                r_nxt.condition_code_word = STACK_DATA;
              end else begin
                r_nxt.condition_code_word[PK_LSB +: PK_W] = STACK_DATA[PK_LSB +: PK_W];
              end
            end
            STK_PULL2: r_nxt.pc = STACK_DATA;
            STK_ADJ: r_nxt.pc = r_r.pc - (r_r.op == OP_RTE ? EXC_PC_ADJ : SUB_PC_ADJ);
            default: r_nxt.pc = r_r.pc;
          endcase
        end
        if (RETIRE) begin
          r_nxt.st = ST_IDLE;
          r_nxt.page = PG_NONE;
          r_nxt.op = OP_NONE;
        end else begin
          r_nxt.step = r_r.step + 4'h1;
        end
      end
      default: r_nxt = CORE_RST;
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      r_r <= CORE_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Port drive
  assign FETCH_READY = (r_r.st == ST_IDLE) || (r_r.st == ST_PAGE);
  assign BUSY = (r_r.st == ST_EXEC);
  assign RETIRE = BUSY && (r_r.step == r_r.cyc - 4'h1);
  assign STACK_RD = BUSY && (r_r.op == OP_RTE || r_r.op == OP_RTS)
    && (r_r.step == STK_RD1 || r_r.step == STK_RD2);
  assign STACK_ADDR = r_r.sp;
  assign MEM_WR = r_r.wr;
  assign MEM_WIDE = r_r.wide;
  assign MEM_WDATA = r_r.wdata;
  assign ILLEGAL = r_r.illegal;
  assign REG_D = {r_r.a, r_r.b};
  assign REG_E = r_r.e;
  assign REG_CCR = r_r.condition_code_word;
  assign REG_PC = r_r.pc;
  assign REG_SP = r_r.sp;

  // Checks on the sequencer
  logic in_pg0;
  logic in_pg27;
  logic in_pg37;
  assign in_pg0 = take_w && r_r.st == ST_IDLE;
  assign in_pg27 = take_w && r_r.st == ST_PAGE && r_r.page == PG_27;
  assign in_pg37 = take_w && r_r.st == ST_PAGE && r_r.page == PG_37;

  property p_sub_with_borrow_acc_a_cyc;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg0 && FETCH_BYTE == 8'h42) |=> !RETIRE [*4] ##1 RETIRE;
  endproperty
  a_sub_with_borrow_acc_a_cyc: assert property (p_sub_with_borrow_acc_a_cyc) else $error("sub_with_borrow_acc_a length wrong");

  property p_sub_with_borrow_acc_b_imm;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg0 && FETCH_BYTE == 8'hF2) |=> RETIRE ##1 FETCH_READY;
  endproperty
  a_sub_with_borrow_acc_b_imm: assert property (p_sub_with_borrow_acc_b_imm) else $error("sub_with_borrow_acc_b imm length wrong");

  property p_sub_with_borrow_acc_d_imm;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg37 && FETCH_BYTE == 8'hB2) |=> !RETIRE [*2] ##1 RETIRE;
  endproperty
  a_sub_with_borrow_acc_d_imm: assert property (p_sub_with_borrow_acc_d_imm) else $error("sub_with_borrow_acc_d imm length wrong");

  property p_sub_with_borrow_acc_e_imm;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg37 && FETCH_BYTE == 8'h32) |-> ##3 RETIRE;
  endproperty
  a_sub_with_borrow_acc_e_imm: assert property (p_sub_with_borrow_acc_e_imm) else $error("sub_with_borrow_acc_e imm length wrong");

  property p_sbc_keep;
    @(posedge SYS_CLK) disable iff (RST)
    (BUSY && r_r.op inside {OP_SUB_WITH_BORROW_ACC_A, OP_SUB_WITH_BORROW_ACC_B, OP_SUB_WITH_BORROW_ACC_D, OP_SUB_WITH_BORROW_ACC_E})
      |=> REG_CCR[15:12] == $past(REG_CCR[15:12]);
  endproperty
  a_sbc_keep: assert property (p_sbc_keep) else $error("upper flags changed");

  property p_rte_seq;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg27 && FETCH_BYTE == 8'h77) |-> ##2 STACK_RD ##3 STACK_RD ##6 RETIRE;
  endproperty
  a_rte_seq: assert property (p_rte_seq) else $error("exception return timing");

  property p_rts_flags;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg27 && FETCH_BYTE == 8'hF7) |-> ##12 REG_CCR[15:4] == $past(REG_CCR[15:4], 12);
  endproperty
  a_rts_flags: assert property (p_rts_flags) else $error("subroutine return flags");

  property p_rot_cyc;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg27 && FETCH_BYTE == 8'h1E) |-> ##2 MEM_WR ##5 RETIRE;
  endproperty
  a_rot_cyc: assert property (p_rot_cyc) else $error("rotate timing");

  property p_sde_val;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg27 && FETCH_BYTE == 8'h79)
      |-> ##2 REG_E == 16'($past(REG_E, 2) - $past(REG_D, 2));
  endproperty
  a_sde_val: assert property (p_sde_val) else $error("E minus D wrong");

  property p_sba_val;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg37 && FETCH_BYTE == 8'h0A)
      |-> ##2 REG_D[15:8] == 8'($past(REG_D[15:8], 2) - $past(REG_D[7:0], 2));
  endproperty
  a_sba_val: assert property (p_sba_val) else $error("A minus B wrong");

  property p_sta_wr;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg0 && FETCH_BYTE == 8'h4A) |-> ##2 MEM_WR && !REG_CCR[CC_V]
      && MEM_WDATA[7:0] == $past(REG_D[15:8], 2) ##1 RETIRE;
  endproperty
  a_sta_wr: assert property (p_sta_wr) else $error("store timing or data");

  property p_add_with_carry_acc_e_imm;
    @(posedge SYS_CLK) disable iff (RST)
    (in_pg37 && FETCH_BYTE == 8'h33) |-> ##3 RETIRE;
  endproperty
  a_add_with_carry_acc_e_imm: assert property (p_add_with_carry_acc_e_imm) else $error("add_with_carry_acc_e imm length wrong");

  property p_prefix;
    @(posedge SYS_CLK) disable iff (RST)
    (FETCH_READY && r_r.st == ST_IDLE && FETCH_VALID && FETCH_BYTE == PFX_27)
      |=> r_r.st == ST_PAGE && r_r.page == PG_27 && !BUSY;
  endproperty
  a_prefix: assert property (p_prefix) else $error("prefix not paged");

  c_rte: cover property (@(posedge SYS_CLK) RETIRE && r_r.op == OP_RTE);
  c_store: cover property (@(posedge SYS_CLK) MEM_WR && !MEM_WIDE);
  c_illegal: cover property (@(posedge SYS_CLK) ILLEGAL);
endmodule

// ===== include/decode_pkg.sv
// Shared constants and types for the instruction decode and sequencing subset
package decode_pkg;

  // Page selector codes for the second opcode byte
  localparam logic [1:0] PG_NONE = 2'h0; // Single-byte opcode page
  localparam logic [1:0] PG_17 = 2'h1; // First prefix page
  localparam logic [1:0] PG_27 = 2'h2; // Second prefix page
  localparam logic [1:0] PG_37 = 2'h3; // Third prefix page
  localparam logic [7:0] PFX_17 = 8'h17; // Prefix byte values
  localparam logic [7:0] PFX_27 = 8'h27;
  localparam logic [7:0] PFX_37 = 8'h37;

  // Cycle counts per instruction form
  localparam logic [3:0] CYC_SHORT = 4'h2; // Immediate 8-bit and inherent
  localparam logic [3:0] CYC_IMM16 = 4'h4; // Immediate 16-bit
  localparam logic [3:0] CYC_STORE_SHORT = 4'h4; // Short store forms
  localparam logic [3:0] CYC_MEM = 4'h6; // Memory operand forms
  localparam logic [3:0] CYC_ROT = 4'h8; // Memory word rotate
  localparam logic [3:0] CYC_STACK = 4'hC; // Stack return sequences

  // Steps of the stack return sequence
  localparam logic [3:0] STK_INC1 = 4'h1; // First pointer bump
  localparam logic [3:0] STK_RD1 = 4'h2; // First stack read strobe
  localparam logic [3:0] STK_PULL1 = 4'h3; // Flags or bank captured
  localparam logic [3:0] STK_INC2 = 4'h4; // Second pointer bump
  localparam logic [3:0] STK_RD2 = 4'h5; // Second stack read strobe
  localparam logic [3:0] STK_PULL2 = 4'h6; // Program counter captured
  localparam logic [3:0] STK_ADJ = 4'h7; // Program counter fix-up
  localparam logic [3:0] STEP_FIRST = 4'h1; // Step where results land
  localparam logic [15:0] SP_STEP = 16'h0002; // Pointer bump size
  localparam logic [15:0] EXC_PC_ADJ = 16'h0006; // Exception return fix-up
  localparam logic [15:0] SUB_PC_ADJ = 16'h0002; // Subroutine return fix-up

  // Condition code word field positions
  localparam int CC_S = 15; // Stop enable
  localparam int CC_MV = 14; // accumulator_overflow_flag
  localparam int CC_H = 13; // Half carry
  localparam int CC_EV = 12; // extension_overflow_flag
  localparam int CC_N = 11; // Negative
  localparam int CC_Z = 10; // Zero
  localparam int CC_V = 9; // Overflow
  localparam int CC_C = 8; // Carry
  localparam int PK_LSB = 0; // program_bank_field low bit
  localparam int PK_W = 4; // program_bank_field width

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, // Waiting for first opcode byte
    ST_PAGE = 2'b01, // Waiting for paged opcode byte
    ST_EXEC = 2'b11 // Counting execution cycles
  } state_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_SUB_WITH_BORROW_ACC_A, OP_SUB_WITH_BORROW_ACC_B, OP_SUB_WITH_BORROW_ACC_D, OP_SUB_WITH_BORROW_ACC_E, OP_RTE, OP_RTS,
    OP_ROTW, OP_SDE, OP_SBAB, OP_STORE_ACC_A, OP_ADD_WITH_CARRY_ACC_E
  } op_t;

  typedef struct packed {
    logic ok; // Opcode recognised
    op_t op; // Operation
    logic [3:0] cyc; // Total cycles
  } dec_t;

  typedef struct packed {
    state_t st; // Sequencer state
    logic [1:0] page; // Selected opcode page
    op_t op; // Operation in progress
    logic [3:0] cyc; // Total cycles of it
    logic [3:0] step; // Execution step
    logic [7:0] a; // Accumulator A
    logic [7:0] b; // Accumulator B
    logic [15:0] e; // Accumulator E
    logic [15:0] condition_code_word; // condition_code_word
    logic [15:0] pc; // Program counter
    logic [15:0] sp; // Stack pointer
    logic [15:0] wdata; // Store data
    logic wr; // Store strobe
    logic wide; // Store is a word
    logic illegal; // Unknown opcode pulse
  } core_t;

  localparam core_t CORE_RST = core_t'('0); // Everything cleared, idle

endpackage

// ===== verilog/addsub_unit.sv
// Add or subtract with carry, byte or word, with flag outputs
module addsub_unit (
  input wire logic [15:0] a, // Left operand
  input wire logic [15:0] b, // Right operand
  input wire logic cin, // Carry or borrow in
  input wire logic sub, // High to subtract
  input wire logic wide, // High for 16-bit
  output logic [15:0] res, // Result
  output logic n, // Negative
  output logic z, // Zero
  output logic v, // Overflow
  output logic c // Carry or borrow out
);
  logic [16:0] full; // Sum with carry bit
  logic [15:0] an; // Masked operands
  logic [15:0] bn;
  logic msb_a; // Sign bits
  logic msb_b;
  logic msb_r;

  // Byte mode ignores the upper bytes
  always_comb begin
    an = wide ? a : {8'h00, a[7:0]};
    bn = wide ? b : {8'h00, b[7:0]};
    if (sub) begin
      full = {1'b0, an} - {1'b0, bn} - {16'h0000, cin};
    end else begin
      full = {1'b0, an} + {1'b0, bn} + {16'h0000, cin};
    end
    res = wide ? full[15:0] : {8'h00, full[7:0]};
    msb_a = wide ? an[15] : an[7];
    msb_b = wide ? bn[15] : bn[7];
    msb_r = wide ? full[15] : full[7];
    n = msb_r;
    z = wide ? (full[15:0] == 16'h0000) : (full[7:0] == 8'h00);
    c = wide ? full[16] : full[8];
    // Overflow when the sign flips against the operands
    if (sub) begin
      v = (msb_a ^ msb_b) & (msb_a ^ msb_r);
    end else begin
      v = ~(msb_a ^ msb_b) & (msb_a ^ msb_r);
    end
  end
endmodule

// ===== verif/fetch_source.sv
// Program memory model: opcode byte stream and stack word reads
module fetch_source (
  input wire logic clk, // System clock
  input wire logic fetch_ready, // Byte taken when offered
  input wire logic stack_rd, // Stack read strobe
  input wire logic [15:0] stack_addr, // Stack read address
  output logic fetch_valid, // Byte offered
  output logic [7:0] fetch_byte, // Offered byte
  output logic [15:0] stack_data // Stack word, cycle after strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$]; // Bytes still to offer
  logic [15:0] mem [0:15]; // Stack words by word index
  int gap = 0; // Idle cycles after each take, for slow answers
  int idle = 0; // Idle cycles left
  logic took = 1'b0; // Byte accepted at last rising edge
  logic rd_q = 1'b0; // Stack strobe seen at last rising edge
  logic [15:0] addr_q = 16'h0000; // Address of that read
  // Quiet outputs at time zero
  initial begin
    fetch_valid = 1'b0;
    fetch_byte = 8'h00;
    stack_data = 16'h0000;
  end
  // Queue a byte behind those already waiting
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // Sample what the block did at the rising edge
  always @(posedge clk) begin
    took <= fetch_valid && fetch_ready;
    rd_q <= stack_rd;
    addr_q <= stack_addr;
  end
  // Outputs change at the falling edge; an offer stands until taken
  always @(negedge clk) begin
    if (took) begin
      void'(q.pop_front());
      idle = gap;
    end
    if (idle > 0 || q.size() == 0) begin
      // Nothing offered: byte lines keep toggling
      fetch_valid <= 1'b0;
      fetch_byte <= ~fetch_byte;
      if (idle > 0) idle = idle - 1;
    end else begin
      fetch_valid <= 1'b1;
      fetch_byte <= q[0];
    end
    // Stack word valid for one cycle only, inverted otherwise
    stack_data <= rd_q ? mem[addr_q[4:1]] : ~stack_data;
  end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the instruction decode and sequencing subset
module tb_top import decode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK, RST, FETCH_VALID, FETCH_READY, STACK_RD, MEM_WR, MEM_WIDE;
  logic BUSY, RETIRE, ILLEGAL;
  logic [7:0] FETCH_BYTE; // Offered byte
  logic [15:0] OPERAND, STACK_DATA, STACK_ADDR, MEM_WDATA, REG_D, REG_E, REG_CCR, REG_PC, REG_SP;
  int miscompares = 0; // Mismatches seen
  int checks_done = 0; // Comparisons made
  int cycles = 0; // Clock cycles run
  int wr_n = 0; // Write strobes in last operation
  logic [15:0] wr_data = 16'h0000; // Last written data
  logic wr_wide = 1'b0; // Last write width
  logic [19:0] sw [] = '{ // Cycle count in the top nibble, then opcode
    20'h60042, 20'h60052, 20'h60062, 20'h20072, 20'h61742, 20'h61752,
    20'h61762, 20'h61772, 20'h62742, 20'h62752, 20'h62762,
    20'h600C2, 20'h600D2, 20'h600E2, 20'h200F2, 20'h617C2, 20'h617D2,
    20'h617E2, 20'h617F2, 20'h627C2, 20'h627D2, 20'h627E2,
    20'h60082, 20'h60092, 20'h600A2, 20'h437B2, 20'h637C2, 20'h637D2,
    20'h637E2, 20'h637F2, 20'h62782, 20'h62792, 20'h627A2,
    20'h43732, 20'h63742, 20'h63752, 20'h63762, 20'h63772,
    20'h8270E, 20'h8271E, 20'h8272E, 20'h8273E, 20'h22779, 20'h2370A,
    20'h4004A, 20'h4005A, 20'h4006A, 20'h6174A, 20'h6175A, 20'h6176A,
    20'h6177A, 20'h4274A, 20'h4275A, 20'h4276A,
    20'h43733, 20'h63743, 20'h63753, 20'h63763, 20'h63773};

  // Far side: program memory and stack
  fetch_source src (.clk(SYS_CLK), .fetch_ready(FETCH_READY), .stack_rd(STACK_RD),
    .stack_addr(STACK_ADDR), .fetch_valid(FETCH_VALID), .fetch_byte(FETCH_BYTE),
    .stack_data(STACK_DATA));
  insn_decoder uut (.SYS_CLK(SYS_CLK), .RST(RST), .FETCH_VALID(FETCH_VALID),
    .FETCH_BYTE(FETCH_BYTE), .FETCH_READY(FETCH_READY), .OPERAND(OPERAND),
    .STACK_DATA(STACK_DATA), .STACK_RD(STACK_RD), .STACK_ADDR(STACK_ADDR), .MEM_WR(MEM_WR),
    .MEM_WIDE(MEM_WIDE), .MEM_WDATA(MEM_WDATA), .BUSY(BUSY), .RETIRE(RETIRE),
    .ILLEGAL(ILLEGAL), .REG_D(REG_D), .REG_E(REG_E), .REG_CCR(REG_CCR), .REG_PC(REG_PC),
    .REG_SP(REG_SP));

  // Clock, 20 ns period
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // Hang guard
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end
  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Queue one opcode, with its page byte if any
  task automatic send(input logic [15:0] code);
    #1;
    if (code[15:8] != 8'h00) src.push(code[15:8]);
    src.push(code[7:0]);
  endtask
  // Run one operation, measure take to retire, capture writes
  task automatic do_op(input logic [15:0] code, input logic [15:0] opnd, input int cyc);
    int tk;
    int t;
    int n;
    tk = 0;
    t = -1;
    n = 0;
    wr_n = 0;
    @(negedge SYS_CLK);
    OPERAND <= opnd;
    for (int k = 0; k < 60; k++) begin
      if (k > 0) @(negedge SYS_CLK);
      // Take flag latched by the source at the rising edge just passed
      if (src.took) tk++;
      if (src.took && tk == ((code[15:8] != 8'h00) ? 2 : 1)) t = k;
      if (BUSY && FETCH_READY) chk("ready while busy", 16'h0000, 16'h0001);
      if (ILLEGAL) t = -99;
      if (MEM_WR) begin
        wr_n++;
        wr_data = MEM_WDATA;
        wr_wide = MEM_WIDE;
      end
      if (RETIRE) begin
        n = k - t;
        break;
      end
    end
    // Take edge ends cycle 0; RETIRE seen at the falling edge of cycle cyc-1
    chk($sformatf("cycles of %h", code), 16'(cyc - 2), 16'(n));
    @(posedge SYS_CLK);
    #1;
  endtask
  // Operation plus result registers
  task automatic op3(input logic [15:0] code, opnd, input int cyc, input logic [15:0] d, e, cc);
    send(code);
    do_op(code, opnd, cyc);
    chk($sformatf("d after %h", code), d, REG_D);
    chk($sformatf("e after %h", code), e, REG_E);
    chk($sformatf("ccr after %h", code), cc, REG_CCR);
  endtask
  // Reset state
  task automatic t_reset();
    chk("regs after reset", 16'h0000, REG_D | REG_E | REG_CCR | REG_PC | REG_SP);
    chk("ready after reset", 16'h0001, {14'h0000, BUSY, FETCH_READY});
  endtask
  // Both stack returns
  task automatic t_returns();
    op3(16'h2777, 16'h0000, CYC_STACK, 16'h0000, 16'h0000, 16'hF005);
    chk("pc exception return", 16'h1230, REG_PC);
    chk("sp exception return", 16'h0004, REG_SP);
    op3(16'h27F7, 16'h0000, CYC_STACK, 16'h0000, 16'h0000, 16'hF00A);
    chk("pc subroutine return", 16'h4442, REG_PC);
    chk("sp subroutine return", 16'h0008, REG_SP);
  endtask
  // Subtract with borrow into A, with and without carry in
  task automatic t_sub_a();
    op3(16'h0072, 16'h0001, 2, 16'hFF00, 16'h0000, 16'hF90A);
    op3(16'h1772, 16'h0010, 6, 16'hEE00, 16'h0000, 16'hF80A);
  endtask
  // E arithmetic with overflow and borrow
  task automatic t_e_ops();
    op3(16'h3733, 16'h7FFF, 4, 16'hEE00, 16'h7FFF, 16'hF00A);
    op3(16'h2779, 16'h0000, 2, 16'hEE00, 16'h91FF, 16'hFB0A);
  endtask
  // Byte store keeps carry, clears overflow
  task automatic t_store();
    op3(16'h004A, 16'h0000, 4, 16'hEE00, 16'h91FF, 16'hF90A);
    chk("store data", 16'h00EE, wr_data);
    chk("store strobes and width", 16'h0100, {wr_n[7:0], 7'h00, wr_wide});
  endtask
  // Borrow into E and B, then A minus B ignoring carry
  task automatic t_sub_e_b();
    op3(16'h3732, 16'h01FF, 4, 16'hEE00, 16'h8FFF, 16'hF80A);
    op3(16'h00F2, 16'h000F, 2, 16'hEEF1, 16'h8FFF, 16'hF90A);
    op3(16'h370A, 16'h0000, 2, 16'hFDF1, 16'h8FFF, 16'hF90A);
  endtask
  // Word borrow to zero, then word rotate through carry
  task automatic t_sub_d_rot();
    op3(16'h37B2, 16'hFDF0, 4, 16'h0000, 16'h8FFF, 16'hF40A);
    op3(16'h270E, 16'h8001, 8, 16'h0000, 16'h8FFF, 16'hF30A);
    chk("rotate data", 16'h4000, wr_data);
    chk("rotate strobes and width", 16'h0101, {wr_n[7:0], 7'h00, wr_wide});
  endtask
  // Every opcode except the two stack returns back to back, next byte offered while busy
  task automatic t_sweep();
    send(sw[0][15:0]);
    foreach (sw[i]) begin
      if (i + 1 < sw.size()) send(sw[i + 1][15:0]);
      do_op(sw[i][15:0], 16'h0000, int'(sw[i][19:16]));
    end
  endtask
  // Unknown opcode flagged, decoder free again
  task automatic t_illegal();
    logic seen;
    seen = 1'b0;
    send(16'h0000);
    repeat (4) begin
      @(negedge SYS_CLK);
      seen = seen | ILLEGAL;
    end
    chk("unknown opcode flag", 16'h0001, {15'h0000, seen});
    chk("ready after unknown", 16'h0001, {14'h0000, BUSY, FETCH_READY});
  endtask
  // Slow fetch stalls between page byte and opcode
  task automatic t_slow();
    src.gap = 3;
    op3(16'h3772, 16'h0FFF, 6, 16'hFE00, 16'h8200, 16'hF80A);
    src.gap = 0;
  endtask
  // Main sequence
  initial begin
    RST = 1'b1;
    OPERAND = 16'h0000;
    src.mem[1] = 16'hF005;
    src.mem[2] = 16'h1236;
    src.mem[3] = 16'h000A;
    src.mem[4] = 16'h4444;
    repeat (4) @(negedge SYS_CLK);
    RST <= 1'b0;
    t_reset();
    t_returns();
    t_sub_a();
    t_e_ops();
    t_store();
    t_sub_e_b();
    t_sub_d_rot();
    t_sweep();
    t_illegal();
    t_slow();
    test_done();
  end
endmodule
